/* File: shared/ppcl_map.svh */
/*
  Constants of the passive parallel configuration loader: data widths,
  width codes, ratio figures, register offsets, field positions, timing.
  Included by ppcl_pkg at package scope and by the testbench at file scope.
*/
// What this block does
// - Ratio r comes from width, decompression and decryption options.
// - With r above one, one word latched per r config clocks.
// - User mode has all lines high; request low starts reconfiguration.
// - Ready/error line held low for the power-on delay.
// - Load-complete line low from power-up and during loading.
// - Load-complete released only after the whole image arrived.
// - Config clock ignored in user mode; host keeps it defined.
// - Init-complete output driven low once its option bit loads.
// - Request low pulls both status lines low within 600 ns.
// - Ready/error low 268 to 1506 us after request rises.
// - Internal oscillator: user mode 175 to 437 us after completion.
// - User clock starts 4 periods after, user mode 8576 periods later.
`ifndef PPCL_MAP_SVH
`define PPCL_MAP_SVH

// ==========================================================
// Widths and codes
`define PPCL_DATA_W 32
`define PPCL_ADDR_W 4
`define PPCL_CNT_W 24
`define PPCL_WID_X8 2'h0
`define PPCL_WID_X16 2'h1
`define PPCL_WID_X32 2'h2
`define PPCL_MASK_X8 32'h0000_00ff
`define PPCL_MASK_X16 32'h0000_ffff
`define PPCL_MASK_X32 32'hffff_ffff
`define PPCL_R_ONE 4'h1
`define PPCL_R8_DECOMP 4'h2
`define PPCL_R16_DECRYPT 4'h2
`define PPCL_R16_DECOMP 4'h4
`define PPCL_R32_DECRYPT 4'h4
`define PPCL_R32_DECOMP 4'h8

// ==========================================================
// Registers and fields
`define PPCL_OFS_CTRL 4'h0
`define PPCL_OFS_LEN 4'h4
`define PPCL_OFS_STAT 4'h8
`define PPCL_OFS_WCNT 4'hc
`define PPCL_CTRL_WID_LSB 0
`define PPCL_CTRL_DECOMP 2
`define PPCL_CTRL_DECRYPT 3
`define PPCL_CTRL_USRCLK 4
`define PPCL_CTRL_W 5
`define PPCL_CTRL_RST 5'h02
`define PPCL_LEN_RST 32'h0000_0100
`define PPCL_INIT_OPT_BIT 0

// ==========================================================
// Timing
`define PPCL_CLK_MHZ 100
`define PPCL_T_REQ_LOW_NS 600
`define PPCL_T_STATUS_MIN_US 268
`define PPCL_T_STATUS_MAX_US 1506
`define PPCL_T_INIT_MIN_US 175
`define PPCL_T_INIT_MAX_US 437
`define PPCL_CD2CU_PERIODS 4
`define PPCL_CFG_CLK_MAX_PERIOD_NS 10
`define PPCL_USR_PERIODS 8576
`define PPCL_POR_CYC 1000

`endif

/* File: shared/ppcl_pkg.sv */
/*
  Types of the passive parallel configuration loader.
  Assumes ppcl_map.svh is on the include path.
*/
package ppcl_pkg;
`include "ppcl_map.svh"

  // ==========================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [`PPCL_DATA_W-1:0] data;
  } ppcl_word_s;

  typedef enum logic [2:0] {
    ST_POR, ST_CLEAR, ST_STLOW, ST_LOAD, ST_TAIL, ST_DONE, ST_INIT, ST_USER
  } ppcl_state_e;

  function automatic logic [3:0] ppcl_ratio(logic [1:0] wid, logic decomp,
                                            logic decrypt);
    logic [3:0] r;
    r = `PPCL_R_ONE;
    if (wid == `PPCL_WID_X8) begin
      if (decomp) r = `PPCL_R8_DECOMP;
    end else if (wid == `PPCL_WID_X16) begin
      if (decomp) r = `PPCL_R16_DECOMP;
      else if (decrypt) r = `PPCL_R16_DECRYPT;
    end else begin
      if (decomp) r = `PPCL_R32_DECOMP;
      else if (decrypt) r = `PPCL_R32_DECRYPT;
    end
    return r;
  endfunction
endpackage

/* File: rtl/ppcl_pin_sync.sv */
/*
  Two-flop synchroniser with edge detection for a group of pins.
  Assumes the pins are asynchronous to clk; rst is synchronous.
*/
`timescale 1ns/1ps
module ppcl_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and results
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  if (W < 1) begin : g_chk
    $error("ppcl_pin_sync: W must be at least 1");
  end

  // ==========================================================
  // Per-bit synchroniser
  // First flop feeds only the second; edges come from later stages
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_reg <= RST_VAL[i];
        sync_reg <= RST_VAL[i];
        last_reg <= RST_VAL[i];
      end else begin
        meta_reg <= pin[i];
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
      end
    end
    assign level[i] = sync_reg;
    assign rise[i] = sync_reg & ~last_reg;
    assign fall[i] = ~sync_reg & last_reg;
  end
endmodule

/* File: rtl/ppcl_loader.sv */
/*
  Device end of the passive parallel configuration load: status lines,
  word capture at ratio r, completion, initialization and user mode.
  Assumes all link pins are asynchronous to CLK_SYS and that the host
  keeps its own timing; the config clock is far slower than CLK_SYS.
*/
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ppcl_loader import ppcl_pkg::*; #(
  parameter int POR_CYC = `PPCL_POR_CYC,
  parameter int STATUS_CYC = `PPCL_T_STATUS_MIN_US * `PPCL_CLK_MHZ,
  parameter int INIT_CYC = `PPCL_T_INIT_MIN_US * `PPCL_CLK_MHZ,
  parameter int USR_PERIODS = `PPCL_USR_PERIODS
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Link from the host
  input wire logic CFG_REQ_N_I,
  input wire logic CONFIG_CLOCK_I,
  input wire logic USER_INIT_CLOCK_I,
  input wire logic [`PPCL_DATA_W-1:0] DATA_I,
  // Open-drain status lines
  input wire logic STATUS_N_I,
  output logic STATUS_N_O,
  output logic STATUS_N_OE_N,
  input wire logic LOAD_DONE_I,
  output logic LOAD_DONE_O,
  output logic LOAD_DONE_OE_N,
  output logic INIT_DONE_N_O,
  output logic INIT_DONE_N_OE_N,
  // User side
  output ppcl_word_s WORD,
  output logic USER_MODE,
  // Register port
  input wire logic [`PPCL_ADDR_W-1:0] REG_ADDR,
  input wire logic [`PPCL_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [`PPCL_DATA_W-1:0] REG_RDATA
);
  localparam int CW = `PPCL_CNT_W;
  localparam int REQ_LOW_CYC =
    `PPCL_T_REQ_LOW_NS * `PPCL_CLK_MHZ / 1000;
  localparam int STATUS_MAX_CYC = `PPCL_T_STATUS_MAX_US * `PPCL_CLK_MHZ;
  localparam int INIT_MAX_CYC = `PPCL_T_INIT_MAX_US * `PPCL_CLK_MHZ;
  localparam int CD2CU_CYC = `PPCL_CD2CU_PERIODS *
    `PPCL_CFG_CLK_MAX_PERIOD_NS * `PPCL_CLK_MHZ / 1000;
  localparam int SW = `PPCL_DATA_W + 5;

  if (POR_CYC < 1 || STATUS_CYC < 1 || STATUS_CYC > STATUS_MAX_CYC ||
      INIT_CYC < 1 || INIT_CYC > INIT_MAX_CYC || USR_PERIODS < 1 ||
      STATUS_MAX_CYC >= (1 << CW) || USR_PERIODS >= (1 << CW) ||
      POR_CYC >= (1 << CW)) begin : g_chk
    $error("ppcl_loader: timing parameter out of range");
  end

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0] s_lvl, s_rise, s_fall;
  // Reset to idle pin levels so no false edge follows reset
  ppcl_pin_sync #(.W(SW), .RST_VAL(SW'(5'h0e))) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin({DATA_I, USER_INIT_CLOCK_I, LOAD_DONE_I, STATUS_N_I,
          CFG_REQ_N_I, CONFIG_CLOCK_I}),
    .level(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );
  logic clk_rise, clk_fall, req_lvl, status_lvl, done_lvl, usr_rise;
  logic [`PPCL_DATA_W-1:0] data_lvl;
  assign clk_rise = s_rise[0];
  assign clk_fall = s_fall[0];
  assign req_lvl = s_lvl[1];
  assign status_lvl = s_lvl[2];
  assign done_lvl = s_lvl[3];
  assign usr_rise = s_rise[4];
  assign data_lvl = s_lvl[SW-1:5];

  // ==========================================================
  // Software registers
  logic [`PPCL_CTRL_W-1:0] ctrl_reg;
  logic [`PPCL_DATA_W-1:0] len_sw_reg;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_reg <= `PPCL_CTRL_RST;
      len_sw_reg <= `PPCL_LEN_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `PPCL_OFS_CTRL) ctrl_reg <= REG_WDATA[`PPCL_CTRL_W-1:0];
      if (REG_ADDR == `PPCL_OFS_LEN) len_sw_reg <= REG_WDATA;
    end
  end

  // ==========================================================
  // State and sequencing
  ppcl_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, ucnt_reg;
  logic [3:0] r_reg, phase_reg;
  logic [`PPCL_DATA_W-1:0] mask_reg, len_reg, words_reg;
  logic usr_opt_reg, fcnt_reg, take, last_word, init_end, entering;

  // Status line may be held low from outside; clock ignored meanwhile
  assign take = state_reg == ST_LOAD && clk_rise && status_lvl &&
                phase_reg == 4'h0;
  assign last_word = words_reg == len_reg - 32'h1;
  assign init_end = usr_opt_reg ? ucnt_reg == CW'(USR_PERIODS)
                                : cnt_reg == CW'(INIT_CYC - 1);
  assign entering = state_next != state_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: if (cnt_reg == CW'(POR_CYC - 1)) state_next = ST_LOAD;
      ST_CLEAR: if (req_lvl) state_next = ST_STLOW;
      ST_STLOW: if (cnt_reg == CW'(STATUS_CYC - 1)) state_next = ST_LOAD;
      ST_LOAD: begin
        if (take && last_word) begin
          state_next = (r_reg == `PPCL_R_ONE) ? ST_DONE : ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (clk_rise && phase_reg == r_reg - 4'h1) state_next = ST_DONE;
      end
      ST_DONE: if (fcnt_reg && clk_fall && done_lvl) state_next = ST_INIT;
      ST_INIT: if (init_end) state_next = ST_USER;
      ST_USER: state_next = ST_USER;
    endcase
    if (!req_lvl && state_reg != ST_POR) state_next = ST_CLEAR;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) state_reg <= ST_POR;
    else state_reg <= state_next;
  end

  // Saturating cycle counter, cleared on every state change
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || entering) cnt_reg <= '0;
    else if (cnt_reg != '1) cnt_reg <= cnt_reg + CW'(1);
  end

  // ratio and lanes fixed at load start
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      r_reg <= `PPCL_R_ONE;
      mask_reg <= `PPCL_MASK_X32;
      len_reg <= `PPCL_LEN_RST;
      usr_opt_reg <= 1'b0;
    end else if (entering && state_next == ST_LOAD) begin
      r_reg <= ppcl_ratio(ctrl_reg[`PPCL_CTRL_WID_LSB +: 2],
                          ctrl_reg[`PPCL_CTRL_DECOMP],
                          ctrl_reg[`PPCL_CTRL_DECRYPT]);
      unique case (ctrl_reg[`PPCL_CTRL_WID_LSB +: 2])
        `PPCL_WID_X8: mask_reg <= `PPCL_MASK_X8;
        `PPCL_WID_X16: mask_reg <= `PPCL_MASK_X16;
        default: mask_reg <= `PPCL_MASK_X32;
      endcase
      len_reg <= len_sw_reg;
      usr_opt_reg <= ctrl_reg[`PPCL_CTRL_USRCLK];
    end
  end

  // phase over r clocks per word
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || (entering && state_next == ST_LOAD)) begin
      phase_reg <= 4'h0;
    end else if ((state_reg == ST_LOAD && status_lvl || state_reg == ST_TAIL)
                 && clk_rise) begin
      phase_reg <= (phase_reg == r_reg - 4'h1) ? 4'h0 : phase_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || (entering && state_next == ST_LOAD)) begin
      words_reg <= '0;
      WORD <= '0;
    end else begin
      WORD.valid <= take;
      if (take) begin
        WORD.data <= data_lvl & mask_reg;
        words_reg <= words_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || state_reg != ST_DONE) fcnt_reg <= 1'b0;
    else if (clk_fall && done_lvl) fcnt_reg <= 1'b1;
  end

  // user clock counted after the start gap
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || state_reg != ST_INIT) ucnt_reg <= '0;
    else if (usr_rise && cnt_reg >= CW'(CD2CU_CYC) &&
             ucnt_reg != CW'(USR_PERIODS)) ucnt_reg <= ucnt_reg + CW'(1);
  end

  // ==========================================================
  // Pin drivers, all registered: outputs held low, enables from the next state and the first word's option bit
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      STATUS_N_O <= 1'b0;
      LOAD_DONE_O <= 1'b0;
      INIT_DONE_N_O <= 1'b0;
    end else begin
      STATUS_N_O <= 1'b0;
      LOAD_DONE_O <= 1'b0;
      INIT_DONE_N_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) STATUS_N_OE_N <= 1'b0;
    else STATUS_N_OE_N <= !(state_next inside {ST_POR, ST_CLEAR, ST_STLOW});
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) LOAD_DONE_OE_N <= 1'b0;
    else LOAD_DONE_OE_N <= state_next inside {ST_DONE, ST_INIT, ST_USER};
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) INIT_DONE_N_OE_N <= 1'b1;
    else if (take && words_reg == '0 && data_lvl[`PPCL_INIT_OPT_BIT])
      INIT_DONE_N_OE_N <= 1'b0;
    else if (state_next inside {ST_USER, ST_CLEAR}) INIT_DONE_N_OE_N <= 1'b1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) USER_MODE <= 1'b0;
    else USER_MODE <= state_next == ST_USER;
  end

  // ==========================================================
  // Register read, data valid the cycle after REG_RD is high, zero otherwise
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !REG_RD) REG_RDATA <= '0;
    else begin
      unique case (REG_ADDR)
        `PPCL_OFS_CTRL: REG_RDATA <= 32'(ctrl_reg);
        `PPCL_OFS_LEN: REG_RDATA <= len_sw_reg;
        `PPCL_OFS_STAT: REG_RDATA <= {24'h0, r_reg, USER_MODE, state_reg};
        `PPCL_OFS_WCNT: REG_RDATA <= words_reg;
        default: REG_RDATA <= '0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  AST_REQ_CLEARS: assert property (
    $fell(req_lvl) && state_reg != ST_POR |-> ##[1:REQ_LOW_CYC]
    (!STATUS_N_OE_N && !LOAD_DONE_OE_N))
    else $error("request low did not pull both lines low");
  AST_POR_LOW: assert property (
    state_reg == ST_POR |-> !STATUS_N_OE_N)
    else $error("ready line released during power-on delay");
  AST_DONE_LOW: assert property (
    state_reg inside {ST_CLEAR, ST_STLOW, ST_LOAD, ST_TAIL} |->
    !LOAD_DONE_OE_N)
    else $error("load-complete released during loading");
  AST_STATUS_MIN: assert property (
    $rose(STATUS_N_OE_N) && $past(state_reg) == ST_STLOW |->
    $past(cnt_reg) == CW'(STATUS_CYC - 1))
    else $error("ready line low time wrong");
  AST_WORD_PHASE: assert property (
    WORD.valid |-> $past(phase_reg) == 4'h0 && $past(clk_rise))
    else $error("word latched off its phase");
  AST_LANES: assert property (
    WORD.valid && mask_reg == `PPCL_MASK_X8 |-> WORD.data[31:8] == 24'h0)
    else $error("unused lanes not masked");
  AST_ALL_WORDS: assert property (
    $rose(LOAD_DONE_OE_N) |-> words_reg == len_reg)
    else $error("load-complete released early");
  AST_RATIO: assert property (
    state_reg == ST_LOAD && ctrl_reg == `PPCL_CTRL_RST |-> r_reg == 4'h1 ||
    $past(state_reg) == ST_LOAD)
    else $error("ratio mismatch");
  AST_USER_IGNORES: assert property (
    state_reg == ST_USER && clk_rise |=> !WORD.valid ##1 !WORD.valid)
    else $error("clock not ignored in user mode");
  AST_USER_LINES: assert property (
    USER_MODE |-> STATUS_N_OE_N && LOAD_DONE_OE_N && INIT_DONE_N_OE_N)
    else $error("status lines not released in user mode");
  AST_INIT_OPT: assert property (
    take && words_reg == '0 && data_lvl[`PPCL_INIT_OPT_BIT] |=>
    !INIT_DONE_N_OE_N)
    else $error("init-complete not driven low");

  COV_LOAD_DONE: cover property ($rose(LOAD_DONE_OE_N));
  COV_USER: cover property ($rose(USER_MODE));
  COV_RELOAD: cover property (state_reg == ST_USER ##1 state_reg == ST_CLEAR);
  COV_TAIL: cover property (state_reg == ST_TAIL ##1 state_reg == ST_DONE);
endmodule

/* File: testbench/ppcl_host_model.sv */
/*
  Behavioural host: request, config clock, data, user clock.
  Assumes pull-ups on both status wires; the bench calls its tasks.
*/
`timescale 1ns/1ps
module ppcl_host_model (
  // Pull-downs from the device
  input wire logic sta_oe_n,
  input wire logic done_oe_n,
  // Host pins
  output logic req_n,
  output logic cclk,
  output logic uclk,
  output logic [31:0] data,
  // Resolved wires
  output logic sta_w,
  output logic done_w
);
  // ==========================================================
  // Wires
  // pull-ups keep both idle high
  assign sta_w = sta_oe_n;
  assign done_w = done_oe_n;
  initial begin
    req_n = 1'b1;
    cclk = 1'b0;
    uclk = 1'b0;
    data = 32'h0;
  end
  // ==========================================================
  // Tasks
  task automatic req(input logic v);
    req_n = v;
  endtask
  // wait for ready, then 2 us
  task automatic wait_rdy();
    for (int i = 0; i < 200 && sta_w !== 1'b1; i++) #10;
    #2000;
  endtask
  // held r clocks, changed while low
  task automatic send(input logic [31:0] w, input int r);
    data = w;
    repeat (r) begin
      #62.5 cclk = 1'b1;
      #62.5 cclk = 1'b0;
    end
  endtask
  task automatic tail(input int n);
    repeat (n) begin
      data = ~data;
      #62.5 cclk = 1'b1;
      #62.5 cclk = 1'b0;
    end
  endtask
  task automatic uclks(input int n);
    repeat (n) begin
      #62.5 uclk = 1'b1;
      #62.5 uclk = 1'b0;
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the loader, with the host model.
  Assumes ppcl_pkg, the loader and the host model compile first.
*/
`timescale 1ns/1ps
`include "ppcl_map.svh"
module testbench import ppcl_pkg::*;;
  logic clk, rst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pins;
  logic req_n, cclk, uclk, sta_w, done_w;
  logic sta_oe_n, done_oe_n, init_oe_n, user_mode;
  ppcl_word_s word;
  int errors = 0;
  int comparisons = 0;
  int nwords = 0;

  // ==========================================================
  // Instances
  ppcl_loader #(.POR_CYC(20), .STATUS_CYC(50), .INIT_CYC(40),
    .USR_PERIODS(8)) i_dut (
    .CLK_SYS(clk), .SYS_RST(rst), .CFG_REQ_N_I(req_n),
    .CONFIG_CLOCK_I(cclk), .USER_INIT_CLOCK_I(uclk), .DATA_I(pins),
    .STATUS_N_I(sta_w), .STATUS_N_O(), .STATUS_N_OE_N(sta_oe_n),
    .LOAD_DONE_I(done_w), .LOAD_DONE_O(), .LOAD_DONE_OE_N(done_oe_n),
    .INIT_DONE_N_O(), .INIT_DONE_N_OE_N(init_oe_n), .WORD(word),
    .USER_MODE(user_mode), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  ppcl_host_model i_host (
    .sta_oe_n(sta_oe_n), .done_oe_n(done_oe_n), .req_n(req_n),
    .cclk(cclk), .uclk(uclk), .data(pins), .sta_w(sta_w),
    .done_w(done_w));

  always @(posedge clk) begin
    if (word.valid === 1'b1) nwords <= nwords + 1;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic restart();
    cyc(1);
    i_host.req(1'b0);
    #600;
    chb("status pull", 1'b0, sta_oe_n);
    chb("done pull", 1'b0, done_oe_n);
    #1400 i_host.req(1'b1);
    cyc(40);
    chb("status held", 1'b0, sta_oe_n);
    cyc(20);
    chb("status freed", 1'b1, sta_oe_n);
    i_host.wait_rdy();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    cyc(15);
    chb("por low", 1'b0, sta_oe_n);
    chb("done low", 1'b0, done_oe_n);
    cyc(10);
    chb("por freed", 1'b1, sta_oe_n);
    rd(`PPCL_OFS_CTRL, d);
    chk("ctrl", 32'h0000_0002, d);
    cyc(1);
    chk("rdata idle", 32'h0, reg_rdata);
    rd(`PPCL_OFS_LEN, d);
    chk("len", 32'h0000_0100, d);
    wr(`PPCL_OFS_WCNT, 32'hffff_ffff);
    rd(`PPCL_OFS_WCNT, d);
    chk("wcnt ro", 32'h0, d);
    rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    $display("reset test done");
  endtask
  task automatic t_ratio();
    logic [31:0] d;
    logic [47:0] tbl;
    tbl = 48'h8841_4421_2211;
    for (int i = 0; i < 12; i++) begin
      wr(`PPCL_OFS_CTRL, {28'h0, i[0], i[1], i[3:2]});
      restart();
      rd(`PPCL_OFS_STAT, d);
      chk("ratio", {28'h0, tbl[4*i +: 4]}, {28'h0, d[7:4]});
    end
    $display("ratio test done");
  endtask
  task automatic t_lanes();
    wr(`PPCL_OFS_CTRL, 32'h4);
    wr(`PPCL_OFS_LEN, 32'h1);
    restart();
    i_host.send(32'hdead_beef, 2);
    i_host.tail(1);
    cyc(6);
    chk("x8 lanes", 32'h0000_00ef, word.data);
    chb("done", 1'b1, done_oe_n);
    $display("lanes test done");
  endtask
  task automatic t_load1();
    logic [31:0] d;
    int n0;
    wr(`PPCL_OFS_CTRL, 32'h2);
    wr(`PPCL_OFS_LEN, 32'h2);
    restart();
    n0 = nwords;
    i_host.send(32'h1234_5671, 1);
    cyc(6);
    chb("done early", 1'b0, done_oe_n);
    chb("init low", 1'b0, init_oe_n);
    i_host.send(32'hcafe_f00d, 1);
    cyc(6);
    chb("done", 1'b1, done_oe_n);
    chk("word", 32'hcafe_f00d, word.data);
    chk("count", 2, nwords - n0);
    rd(`PPCL_OFS_WCNT, d);
    chk("wcnt", 32'h2, d);
    i_host.tail(2);
    cyc(25);
    chb("early user", 1'b0, user_mode);
    cyc(25);
    chb("user", 1'b1, user_mode);
    chb("ready high", 1'b1, sta_w);
    chb("done high", 1'b1, done_w);
    i_host.tail(3);
    chk("ignored", 2, nwords - n0);
    $display("load test done");
  endtask
  task automatic t_ratio8();
    int n0;
    wr(`PPCL_OFS_CTRL, 32'h16);
    wr(`PPCL_OFS_LEN, 32'h1);
    restart();
    n0 = nwords;
    i_host.send(32'h8765_4320, 7);
    cyc(6);
    chk("one word", 1, nwords - n0);
    chb("done tail", 1'b0, done_oe_n);
    chb("no init", 1'b1, init_oe_n);
    i_host.send(32'h8765_4320, 1);
    cyc(6);
    chb("done", 1'b1, done_oe_n);
    i_host.tail(2);
    cyc(10);
    i_host.uclks(7);
    chb("early user", 1'b0, user_mode);
    i_host.uclks(1);
    cyc(10);
    chb("user", 1'b1, user_mode);
    $display("user clock test done");
  endtask

  // ==========================================================
  // Run
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ratio();
    t_lanes();
    t_load1();
    t_ratio8();
    print_verdict();
  end
endmodule
